// ===== logic/data_space_dev.sv
// Data-space mapper: ROM window, fixed RAM, banked RAM/EEPROM/display RAM
`timescale 1ns/1ps
module data_space_dev #(
    parameter int unsigned PROG_CYCLES = dspace_pkg::PROG_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    dspace_if.dev bus,
    input wire logic rom_load_we,
    input wire logic [dspace_pkg::ROM_AW-1:0] rom_load_addr,
    input wire logic [7:0] rom_load_data,
    output logic eeprom_busy,
    output logic eeprom_sleep
);
    import dspace_pkg::*;

    typedef struct packed {
        logic [7:0] win;
        logic [7:0] bank;
        logic standby;
        logic arm;
        logic go;
        logic permit;
        logic row_valid;
        logic [5:0] row_tag;
        logic [7:0] row_seen;
        logic [ROW_BYTES-1:0][7:0] row_bytes;
        logic row_mode;
        logic [8:0] pend_idx;
        logic [7:0] pend_data;
        logic [7:0] rdata;
    } dev_state_t;

    dev_state_t s_q, s_d;

    // Memories
    logic [7:0] rom [2**ROM_AW];
    logic [7:0] fixed_ram [64];
    logic [7:0] bank_ram [192];
    logic [7:0] osd_ram [128];
    logic [7:0] ee [EE_PAGES*64];

    logic [7:0] a;
    logic [1:0] region;
    logic ee_hit, ram_hit, osd_hit;
    logic [2:0] ee_page;
    logic [1:0] ram_pg;
    logic osd_pg;
    logic [8:0] ee_idx;
    logic [7:0] ram_idx;
    logic [6:0] osd_idx;
    logic busy, done, launch, ee_ok;
    logic ram_we, osd_we, fixed_we;

    ////////////////////////////////////////////////////////////////////////
    // Programming interval

    prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(launch),
        .busy(busy),
        .done(done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bank decode

    always_comb begin
        a = bus.addr;
        region = a[7:6];
        ee_hit = s_q.bank[1:0] != 2'h0;
        ram_hit = !ee_hit && (s_q.bank[BANK_RAM_LO+2:BANK_RAM_LO] != 3'h0);
        osd_hit = !ee_hit && !ram_hit && (s_q.bank[BANK_OSD_LO+1:BANK_OSD_LO] != 2'h0);
        // 01-03 give pages 0-2, 81-83 give pages 3-5
        ee_page = s_q.bank[BANK_EE_HI] ? {1'b0, s_q.bank[1:0]} + 3'd2
                                       : {1'b0, s_q.bank[1:0]} - 3'd1;
        ram_pg = s_q.bank[BANK_RAM_LO] ? 2'd0 : (s_q.bank[BANK_RAM_LO+1] ? 2'd1 : 2'd2);
        osd_pg = !s_q.bank[BANK_OSD_LO];
        ee_idx = {ee_page, a[5:0]};
        ram_idx = {ram_pg, a[5:0]};
        osd_idx = {osd_pg, a[5:0]};
        // Busy or standby blocks the core from the array
        ee_ok = !s_q.standby && !busy;
        fixed_we = bus.we && region == REG_FIXED;
        ram_we = bus.we && region == REG_BANKED && ram_hit;
        osd_we = bus.we && region == REG_BANKED && osd_hit;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register and EEPROM control

    always_comb begin
        s_d = s_q;
        launch = 1'b0;
        // Read data, valid the cycle after the strobe
        if (bus.re) begin
            s_d.rdata = 8'h00;
            case (region)
                REG_WINDOW: s_d.rdata = rom[{s_q.win, a[5:0]}];
                REG_FIXED: s_d.rdata = fixed_ram[a[5:0]];
                REG_BANKED: begin
                    if (ee_hit) begin
                        s_d.rdata = ee_ok ? ee[ee_idx] : 8'h00;
                    end else if (ram_hit) begin
                        s_d.rdata = bank_ram[ram_idx];
                    end else if (osd_hit) begin
                        s_d.rdata = osd_ram[osd_idx];
                    end
                end
                default: begin
                    if (a == EE_CTL_ADDR) begin
                        s_d.rdata[CTL_BUSY] = busy;
                        s_d.rdata[CTL_GO] = s_q.go && !busy;
                    end
                end
            endcase
        end
        // Write-only window and bank registers
        if (bus.we && a == ROM_WIN_ADDR) begin
            s_d.win = bus.wdata;
        end
        if (bus.we && a == BANK_ADDR) begin
            s_d.bank = bus.wdata;
        end
        // Control register, locked while programming
        if (bus.we && a == EE_CTL_ADDR && !busy) begin
            s_d.standby = bus.wdata[CTL_STANDBY];
            s_d.permit = bus.wdata[CTL_PERMIT];
            s_d.arm = bus.wdata[CTL_ARM];
            if (bus.wdata[CTL_ARM] && !s_q.arm) begin
                s_d.row_seen = '0;
                s_d.row_valid = 1'b0;
            end
            if (!bus.wdata[CTL_ARM]) begin
                s_d.row_valid = 1'b0;
                s_d.row_seen = '0;
            end
            if (bus.wdata[CTL_GO] && s_q.arm && s_q.permit && !s_q.go) begin
                s_d.go = 1'b1;
                s_d.arm = 1'b1;
                s_d.row_mode = 1'b1;
                launch = 1'b1;
            end
        end
        // EEPROM data write
        if (bus.we && region == REG_BANKED && ee_hit && ee_ok && s_q.permit) begin
            if (s_q.arm && !s_q.go) begin
                if (!s_q.row_valid) begin
                    s_d.row_valid = 1'b1;
                    s_d.row_tag = ee_idx[8:3];
                    s_d.row_seen[a[2:0]] = 1'b1;
                    s_d.row_bytes[a[2:0]] = bus.wdata;
                end else if (s_q.row_tag == ee_idx[8:3]) begin
                    s_d.row_seen[a[2:0]] = 1'b1;
                    s_d.row_bytes[a[2:0]] = bus.wdata;
                end
            end else if (!s_q.arm) begin
                s_d.pend_idx = ee_idx;
                s_d.pend_data = bus.wdata;
                s_d.row_mode = 1'b0;
                launch = 1'b1;
            end
        end
        // End of the interval frees the EEPROM
        if (done) begin
            if (s_q.row_mode) begin
                s_d.arm = 1'b0;
                s_d.go = 1'b0;
                s_d.row_valid = 1'b0;
                s_d.row_seen = '0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.win <= WIN_RESET;
            s_q.bank <= BANK_RESET;
            {s_q.standby, s_q.arm, s_q.go, s_q.permit} <= CTL_RESET[3:0];
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory writes

    always_ff @(posedge clk_sys) begin
        if (rom_load_we) begin
            rom[rom_load_addr] <= rom_load_data;
        end
        if (fixed_we) begin
            fixed_ram[a[5:0]] <= bus.wdata;
        end
        if (ram_we) begin
            bank_ram[ram_idx] <= bus.wdata;
        end
        if (osd_we) begin
            osd_ram[osd_idx] <= bus.wdata;
        end
        // Array changes only when the interval ends
        if (done && !s_q.row_mode) begin
            ee[s_q.pend_idx] <= s_q.pend_data;
        end
        for (int i = 0; i < ROW_BYTES; i++) begin
            if (done && s_q.row_mode && s_q.row_valid && s_q.row_seen[i]) begin
                ee[{s_q.row_tag, 3'(i)}] <= s_q.row_bytes[i];
            end
        end
    end

    assign bus.rdata = s_q.rdata;
    assign eeprom_busy = busy;
    assign eeprom_sleep = s_q.standby;
endmodule

// ===== logic/dspace_pkg.sv
// Shared constants for the data-space mapper and its CPU-side driver
package dspace_pkg;
    // Data-space register addresses
    localparam logic [7:0] ROM_WIN_ADDR = 8'hc9;
    localparam logic [7:0] BANK_ADDR = 8'he8;
    localparam logic [7:0] EE_CTL_ADDR = 8'hea;
    // Regions by address bits 7:6
    localparam logic [1:0] REG_BANKED = 2'h0;
    localparam logic [1:0] REG_WINDOW = 2'h1;
    localparam logic [1:0] REG_FIXED = 2'h2;
    localparam logic [1:0] REG_PERIPH = 2'h3;
    // Control register fields; control, window and bank reset values
    localparam int CTL_STANDBY = 6;
    localparam logic [7:0] CTL_TEST_MASK = 8'h30;
    localparam int CTL_GO = 3;
    localparam int CTL_ARM = 2;
    localparam int CTL_BUSY = 1;
    localparam int CTL_PERMIT = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] WIN_RESET = 8'h00;
    localparam logic [7:0] BANK_RESET = 8'h00;
    // Bank select fields
    localparam int BANK_EE_HI = 7;
    localparam int BANK_RAM_LO = 2;
    localparam int BANK_OSD_LO = 5;
    // Sizes
    localparam int ROM_AW = 14;
    localparam int ROW_BYTES = 8;
    localparam int EE_PAGES = 6;
    // Programming time
    localparam int PROG_TIME_US = 5000;
    localparam int CLK_MHZ = 100;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    // Host command port registers
    localparam logic [2:0] H_ADDR = 3'h0;
    localparam logic [2:0] H_WDATA = 3'h1;
    localparam logic [2:0] H_CMD = 3'h2;
    localparam logic [2:0] H_RESULT = 3'h3;
    localparam logic [2:0] H_STATUS = 3'h4;
    localparam logic [2:0] H_WIN_COPY = 3'h5;
    localparam logic [2:0] H_BANK_COPY = 3'h6;
    localparam int CMD_WRITE = 0;
    localparam int CMD_READ = 1;
    // Host sequencer states
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_ISSUE = 2'b01,
        H_CAPTURE = 2'b11
    } host_state_t;
endpackage

// ===== logic/dspace_if.sv
// Data-space bus between the CPU side and the mapper
`timescale 1ns/1ps
interface dspace_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
    logic [7:0] rdata;
    modport dev(input addr, input wdata, input we, input re, output rdata);
    modport cpu(output addr, output wdata, output we, output re, input rdata);
endinterface

// ===== logic/prog_timer.sv
// Programming interval timer with busy level and done pulse
`timescale 1ns/1ps
module prog_timer #(
    parameter int unsigned CYCLES = dspace_pkg::PROG_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    output logic busy,
    output logic done
);
    import dspace_pkg::*;
    localparam int CW = $clog2(CYCLES + 1);
    typedef struct packed {
        logic busy;
        logic [CW-1:0] cnt;
    } timer_state_t;
    timer_state_t s_q, s_d;

    // Count down while busy, pulse done on the last cycle
    always_comb begin
        s_d = s_q;
        done = 1'b0;
        if (s_q.busy) begin
            if (s_q.cnt == '0) begin
                s_d.busy = 1'b0;
                done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - 1'b1;
            end
        end else if (start) begin
            s_d.busy = 1'b1;
            s_d.cnt = CW'(CYCLES - 1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
endmodule

// ===== logic/data_space_cpu.sv
// CPU-side driver issuing data-space accesses from a command port
`timescale 1ns/1ps
module data_space_cpu (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [2:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_we,
    input wire logic sw_re,
    output logic [7:0] sw_rdata,
    dspace_if.cpu bus
);
    import dspace_pkg::*;

    typedef struct packed {
        host_state_t st;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic is_read;
        logic [7:0] bus_addr;
        logic [7:0] bus_wdata;
        logic bus_we;
        logic bus_re;
        logic [7:0] result;
        logic res_valid;
        logic refused;
        logic [7:0] win_copy;
        logic [7:0] bank_copy;
        logic arm_copy;
        logic [7:0] sw_rdata;
    } host_reg_t;

    host_reg_t s_q, s_d;

    // Only single-bank values are legal
    function automatic logic legal_bank(input logic [7:0] v);
        case (v)
            8'h01, 8'h02, 8'h03, 8'h81, 8'h82, 8'h83: legal_bank = 1'b1;
            8'h04, 8'h08, 8'h10, 8'h20, 8'h40: legal_bank = 1'b1;
            default: legal_bank = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Command port and bus sequencer

    always_comb begin
        s_d = s_q;
        s_d.bus_we = 1'b0;
        s_d.bus_re = 1'b0;
        if (sw_re) begin
            case (sw_addr)
                H_ADDR: s_d.sw_rdata = s_q.addr;
                H_WDATA: s_d.sw_rdata = s_q.wdata;
                H_RESULT: s_d.sw_rdata = s_q.result;
                H_STATUS: s_d.sw_rdata = {5'h0, s_q.refused, s_q.res_valid,
                                          s_q.st != H_IDLE};
                H_WIN_COPY: s_d.sw_rdata = s_q.win_copy;
                H_BANK_COPY: s_d.sw_rdata = s_q.bank_copy;
                default: s_d.sw_rdata = 8'h00;
            endcase
        end
        if (sw_we && sw_addr == H_ADDR) begin
            s_d.addr = sw_wdata;
        end
        if (sw_we && sw_addr == H_WDATA) begin
            s_d.wdata = sw_wdata;
        end
        if (sw_we && sw_addr == H_STATUS) begin
            s_d.refused = 1'b0;
        end
        case (s_q.st)
            H_IDLE: begin
                if (sw_we && sw_addr == H_CMD && sw_wdata[CMD_WRITE]) begin
                    if (s_q.addr == BANK_ADDR && !legal_bank(s_q.wdata)) begin
                        s_d.refused = 1'b1;
                    end else begin
                        // Copies change before the register itself
                        if (s_q.addr == ROM_WIN_ADDR) begin
                            s_d.win_copy = s_q.wdata;
                        end
                        if (s_q.addr == BANK_ADDR) begin
                            s_d.bank_copy = s_q.wdata;
                        end
                        s_d.bus_wdata = s_q.wdata;
                        if (s_q.addr == EE_CTL_ADDR) begin
                            s_d.bus_wdata = s_q.wdata & ~CTL_TEST_MASK;
                            s_d.arm_copy = s_q.wdata[CTL_ARM] && !s_q.wdata[CTL_GO];
                        end
                        s_d.bus_addr = s_q.addr;
                        s_d.bus_we = 1'b1;
                        s_d.is_read = 1'b0;
                        s_d.st = H_ISSUE;
                    end
                end else if (sw_we && sw_addr == H_CMD && sw_wdata[CMD_READ]) begin
                    if (s_q.arm_copy && s_q.addr[7:6] == REG_BANKED
                        && s_q.bank_copy[1:0] != 2'h0) begin
                        s_d.refused = 1'b1;
                    end else begin
                        s_d.bus_addr = s_q.addr;
                        s_d.bus_re = 1'b1;
                        s_d.is_read = 1'b1;
                        s_d.res_valid = 1'b0;
                        s_d.st = H_ISSUE;
                    end
                end
            end
            H_ISSUE: begin
                s_d.st = s_q.is_read ? H_CAPTURE : H_IDLE;
            end
            H_CAPTURE: begin
                s_d.result = bus.rdata;
                s_d.res_valid = 1'b1;
                s_d.st = H_IDLE;
            end
            default: s_d.st = H_IDLE;
        endcase
        if (sw_we && sw_addr == H_CMD && s_q.st != H_IDLE) begin
            s_d.refused = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.st <= H_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.addr = s_q.bus_addr;
    assign bus.wdata = s_q.bus_wdata;
    assign bus.we = s_q.bus_we;
    assign bus.re = s_q.bus_re;
    assign sw_rdata = s_q.sw_rdata;
endmodule

// ===== verification/data_space_properties.sv
// Checker watching the data-space bus between the two ends
`timescale 1ns/1ps
module data_space_properties #(
    parameter int unsigned PROG_CYCLES = dspace_pkg::PROG_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic we,
    input wire logic re,
    input wire logic [7:0] rdata,
    input wire logic eeprom_busy,
    input wire logic eeprom_sleep
);
    import dspace_pkg::*;
    logic [7:0] bank_q;
    logic [31:0] busy_n_q;
    logic [7:0] fix_q [64];
    logic [63:0] fix_ok_q;
    logic [7:0] fix_exp_q;
    logic fix_chk_q;
    logic ee_sel;
    assign ee_sel = bank_q[1:0] != 2'h0;
    ////////////////////////////////////////////////////////////////
    // Shadow of bank, fixed RAM and busy length
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bank_q <= BANK_RESET;
            busy_n_q <= '0;
            fix_ok_q <= '0;
            fix_chk_q <= 1'b0;
        end else begin
            busy_n_q <= eeprom_busy ? busy_n_q + 32'h1 : 32'h0;
            fix_exp_q <= fix_q[addr[5:0]];
            fix_chk_q <= re && addr[7:6] == REG_FIXED && fix_ok_q[addr[5:0]];
            if (we && addr == BANK_ADDR) begin
                bank_q <= wdata;
            end
            if (we && addr[7:6] == REG_FIXED) begin
                fix_q[addr[5:0]] <= wdata;
                fix_ok_q[addr[5:0]] <= 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Strobe discipline and read answer
    a_strobes_apart: assert property (!(we && re))
        else $error("write and read strobe together");
    a_strobe_single: assert property ((we || re) |=> !(we || re))
        else $error("strobe longer than one cycle");
    a_rdata_holds: assert property (!re |=> $stable(rdata))
        else $error("read data moved without a read");
    // Mapping of regions
    a_wo_reads_zero: assert property (re && (addr == ROM_WIN_ADDR || addr == BANK_ADDR)
        |=> rdata == 8'h00)
        else $error("write-only register read back");
    a_fixed_ram: assert property (fix_chk_q |-> rdata == fix_exp_q)
        else $error("fixed RAM read wrong");
    // Programming interval
    a_busy_cause: assert property ($rose(eeprom_busy) |-> $past(we)
        && ($past(addr) == EE_CTL_ADDR || $past(addr) < 8'h40))
        else $error("busy rose without a write");
    a_busy_length: assert property ($fell(eeprom_busy)
        |-> busy_n_q == 32'(PROG_CYCLES))
        else $error("programming interval wrong length");
    a_busy_ctl_read: assert property (re && addr == EE_CTL_ADDR && eeprom_busy
        |=> rdata == 8'h02)
        else $error("control read while busy wrong");
    a_ee_blocked: assert property (re && addr[7:6] == REG_BANKED && ee_sel
        && (eeprom_busy || eeprom_sleep) |=> rdata == 8'h00)
        else $error("blocked EEPROM read gave data");
    a_sleep_write: assert property (we && addr == EE_CTL_ADDR && !eeprom_busy
        |=> eeprom_sleep == $past(wdata[6]))
        else $error("standby bit not taken");
    a_ctl_frozen: assert property (we && addr == EE_CTL_ADDR && eeprom_busy
        |=> $stable(eeprom_sleep))
        else $error("control write taken while busy");
    a_test_bits_zero: assert property (we && addr == EE_CTL_ADDR
        |-> (wdata & CTL_TEST_MASK) == 8'h00)
        else $error("test bits written nonzero");
endmodule

// ===== verification/tb_data_space_bank_eeprom_access.sv
// Bench joining CPU side and mapper, checked against a behavioural model
`timescale 1ns/1ps
`define CHK(g, e) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("CHECK FAILED at %0t: got %h expected %h", $time, (g), (e)); \
    end \
end
module tb_data_space_bank_eeprom_access;
    import dspace_pkg::*;
    localparam int unsigned PROG = 60;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] sw_addr = 3'h0;
    logic [7:0] sw_wdata = 8'h00;
    logic sw_we = 1'b0;
    logic sw_re = 1'b0;
    logic [7:0] sw_rdata;
    logic rom_load_we = 1'b0;
    logic [ROM_AW-1:0] rom_load_addr = '0;
    logic [7:0] rom_load_data = 8'h00;
    logic eeprom_busy;
    logic eeprom_sleep;
    int num_errors = 0;
    int n_checks = 0;
    logic [7:0] rom [int];
    logic [7:0] mem [int];
    logic [7:0] win = 8'h00;
    logic [7:0] bank = 8'h00;
    logic [7:0] banks [11] = '{8'h01, 8'h02, 8'h03, 8'h81, 8'h82, 8'h83,
                              8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
    logic [7:0] d;
    int k;
    ////////////////////////////////////////////////////////////////
    dspace_if dspace_if_i ();
    data_space_dev #(.PROG_CYCLES(PROG)) data_space_dev_i (.clk_sys(clk_sys),
        .rst_n(rst_n), .bus(dspace_if_i.dev), .rom_load_we(rom_load_we),
        .rom_load_addr(rom_load_addr), .rom_load_data(rom_load_data),
        .eeprom_busy(eeprom_busy), .eeprom_sleep(eeprom_sleep));
    data_space_cpu data_space_cpu_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re),
        .sw_rdata(sw_rdata), .bus(dspace_if_i.cpu));
    data_space_properties #(.PROG_CYCLES(PROG)) data_space_properties_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .addr(dspace_if_i.addr),
        .wdata(dspace_if_i.wdata), .we(dspace_if_i.we), .re(dspace_if_i.re),
        .rdata(dspace_if_i.rdata), .eeprom_busy(eeprom_busy),
        .eeprom_sleep(eeprom_sleep));
    // Clock
    always #5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////
    // Verdict and closing
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Host port cycles
    task automatic sw_wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        sw_addr <= a;
        sw_wdata <= v;
        sw_we <= 1'b1;
        @(posedge clk_sys);
        sw_we <= 1'b0;
    endtask
    task automatic sw_rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        sw_addr <= a;
        sw_re <= 1'b1;
        @(posedge clk_sys);
        sw_re <= 1'b0;
        #1;
        v = sw_rdata;
    endtask
    // Data-space write and read through the CPU side
    task automatic dsw(input logic [7:0] a, input logic [7:0] v);
        sw_wr(H_ADDR, a);
        sw_wr(H_WDATA, v);
        sw_wr(H_CMD, 8'h01);
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic dsr(input logic [7:0] a, output logic [7:0] v);
        sw_wr(H_ADDR, a);
        sw_wr(H_CMD, 8'h02);
        repeat (3) @(posedge clk_sys);
        sw_rd(H_RESULT, v);
    endtask
    task automatic wait_idle();
        int t;
        for (t = 0; t < 400 && eeprom_busy !== 1'b0; t++) begin
            @(posedge clk_sys);
            #1;
        end
        if (t == 400) begin
            num_errors++;
            report_and_stop();
        end
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic rom_put(input logic [13:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        rom_load_addr <= a;
        rom_load_data <= v;
        rom_load_we <= 1'b1;
        @(posedge clk_sys);
        rom_load_we <= 1'b0;
        rom[a] = v;
    endtask
    // Model of the mapping
    function automatic int key(input logic [7:0] a);
        return (a[7:6] == REG_BANKED) ? 256 * (bank + 1) + a : a;
    endfunction
    function automatic logic [7:0] expect_at(input logic [7:0] a);
        if (a[7:6] == REG_WINDOW) begin
            return rom[{win, a[5:0]}];
        end
        return mem[key(a)];
    endfunction
    task automatic mwr(input logic [7:0] a, input logic [7:0] v);
        dsw(a, v);
        if (a == ROM_WIN_ADDR) win = v;
        if (a == BANK_ADDR) bank = v;
        if (a[7:6] == REG_BANKED || a[7:6] == REG_FIXED) mem[key(a)] = v;
        if (a[7:6] == REG_BANKED && bank[1:0] != 2'h0) wait_idle();
    endtask
    task automatic chk_rd(input logic [7:0] a);
        logic [7:0] v;
        dsr(a, v);
        `CHK(v, expect_at(a))
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        k = $urandom(32'hb8b9);
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        dsr(EE_CTL_ADDR, d);
        `CHK(d, CTL_RESET)
        $display("Test reset done");
        for (int i = 0; i < 4; i++) begin
            win = (i == 3) ? 8'hff : 8'($urandom);
            rom_put({win, 6'(i * 21)}, 8'($urandom));
            mwr(ROM_WIN_ADDR, win);
            chk_rd(8'h40 + 8'(i * 21));
        end
        sw_rd(H_WIN_COPY, d);
        `CHK(d, win)
        dsr(ROM_WIN_ADDR, d);
        `CHK(d, 8'h00)
        $display("Test window done");
        mwr(EE_CTL_ADDR, 8'h01);
        mwr(8'h80, 8'($urandom));
        mwr(8'hbf, 8'($urandom));
        foreach (banks[i]) begin
            mwr(BANK_ADDR, banks[i]);
            mwr(8'h05, 8'($urandom));
        end
        foreach (banks[i]) begin
            mwr(BANK_ADDR, banks[i]);
            chk_rd(8'h05);
        end
        chk_rd(8'h80);
        chk_rd(8'hbf);
        dsw(BANK_ADDR, 8'h05);
        sw_rd(H_STATUS, d);
        `CHK(d[2], 1'b1)
        chk_rd(8'h05);
        sw_rd(H_BANK_COPY, d);
        `CHK(d, bank)
        $display("Test banks done");
        mwr(BANK_ADDR, 8'h01);
        mwr(EE_CTL_ADDR, 8'h00);
        dsw(8'h05, ~expect_at(8'h05));
        `CHK(eeprom_busy, 1'b0)
        chk_rd(8'h05);
        mwr(EE_CTL_ADDR, 8'h01);
        dsw(8'h06, 8'h3c);
        `CHK(eeprom_busy, 1'b1)
        dsr(EE_CTL_ADDR, d);
        `CHK(d, 8'h02)
        dsr(8'h05, d);
        `CHK(d, 8'h00)
        dsw(EE_CTL_ADDR, 8'h40);
        `CHK(eeprom_sleep, 1'b0)
        wait_idle();
        mem[key(8'h06)] = 8'h3c;
        chk_rd(8'h06);
        mwr(EE_CTL_ADDR, 8'h71);
        `CHK(eeprom_sleep, 1'b1)
        dsr(8'h06, d);
        `CHK(d, 8'h00)
        mwr(EE_CTL_ADDR, 8'h01);
        `CHK(eeprom_sleep, 1'b0)
        $display("Test byte mode done");
        mwr(BANK_ADDR, 8'h02);
        mwr(8'h21, 8'($urandom));
        mwr(EE_CTL_ADDR, 8'h05);
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            dsw(8'h10 + 8'(i), d);
            mem[key(8'h10 + 8'(i))] = d;
        end
        // Read of the EEPROM bank while armed is held back by the CPU side
        sw_wr(H_STATUS, 8'h00);
        sw_wr(H_ADDR, 8'h10);
        sw_wr(H_CMD, 8'h02);
        sw_rd(H_STATUS, d);
        `CHK(d[2], 1'b1)
        dsw(8'h21, ~expect_at(8'h21));
        `CHK(eeprom_busy, 1'b0)
        dsw(EE_CTL_ADDR, 8'h0d);
        `CHK(eeprom_busy, 1'b1)
        wait_idle();
        for (int i = 0; i < 3; i++) begin
            chk_rd(8'h10 + 8'(i));
        end
        chk_rd(8'h21);
        dsr(EE_CTL_ADDR, d);
        `CHK(d, 8'h00)
        mwr(EE_CTL_ADDR, 8'h05);
        dsw(8'h10, ~expect_at(8'h10));
        mwr(EE_CTL_ADDR, 8'h01);
        mwr(EE_CTL_ADDR, 8'h09);
        `CHK(eeprom_busy, 1'b0)
        chk_rd(8'h10);
        $display("Test row mode done");
        report_and_stop();
    end
endmodule
